// [logic/pfr_flags_reg.sv]
// processor flags register: storage, single step, interrupt masking, i/o check
// register port: 0x00 flags low word, 0x04 flags high word (zero),
// 0x08 event status (write one to clear), 0x0c event mask
// outputs: 64-bit flags view, legacy 32-bit view, one-cycle event
// pulses and a level interrupt line
// assumes core strobes are one-cycle pulses synchronous to clk
// assumes the core acts on the accept and fault pulses itself
// assumes reset is asynchronous, active low, released off the edge
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ns

module pfr_flags_reg (
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    // core privilege context
    input wire logic [1:0] currentPrivilegeLevel,
    input wire logic v86ModeExtensionsEnable,
    input wire logic protectedVirtualInterruptEnable,
    // arithmetic result status update
    input wire logic statusWe,
    input wire logic [5:0] statusVal,
    // instruction retire and flag loads
    input wire logic instrRetire,
    input wire logic flagsLoad,
    input wire logic [31:0] flagsLoadData,
    input wire logic taskGateXfer,
    // interrupt and exception sources
    input wire logic maskableIrq,
    input wire logic nmiReq,
    input wire logic softIntReq,
    input wire logic excTaken,
    input wire logic ioAttempt,
    // outputs
    output logic [63:0] flagsControlStatus,
    output logic [31:0] legacy32bitFlagsView,
    output logic debugException,
    output logic generalProtectionFault,
    output logic ioGrant,
    output logic irqAccept,
    output logic nmiAccept,
    output logic intOut
);

    // ==========================================================
    // bit map of the stored low 22 bits, upper 42 always zero:
    //   0 carry, 1 fixed one, 2 parity, 3 fixed zero
    //   4 auxiliary carry, 5 fixed zero, 6 zero, 7 sign
    //   8 single step trap, 9 interrupt enable
    //   10 direction, 11 overflow, 13:12 i/o privilege
    //   14 nested task, 15 fixed zero, 16 resume
    //   17 v86 mode, 18 alignment check
    //   19 virtual interrupt, 20 virtual pending
    //   21 feature probe, writable so software can probe it
    //
    // event bits: 0 debug exception, 1 protection fault,
    //   2 maskable interrupt accepted, 3 non-maskable accepted
    //
    // same-cycle priority inside one clock:
    //   status update first, then register write,
    //   then flag reload, then retire handling,
    //   then any taken interrupt or exception,
    //   which drops the trap bit last of all
    //
    // hazards kept in mind:
    //   v86 bit never moves from the register port
    //   privilege field writable from the port only at level zero
    //   interrupt enable writes may land in the virtual bit
    //   event status set beats a same-cycle clear
    //   read data stands one cycle, zero otherwise
    //
    // ==========================================================
    // state
    typedef struct packed {
        // flag storage, low 22 bits of the 64-bit view
        logic [21:0] flg;
        // next retire raises the debug exception
        logic stepArmed;
        // resume clear skipped on a retire that comes with a reload or task gate
        logic rfDefer;
        // sticky event bits, write one to clear
        logic [3:0] evtStat;
        // event mask, same layout as status
        logic [3:0] evtMask;
        // registered read word
        logic [31:0] rdData;
        // one-cycle output pulses
        logic dbgExc;
        logic gpFlt;
        logic ioOk;
        logic irqAck;
        logic nmiAck;
        // level interrupt line
        logic irq;
    } pfr_state_t;

    pfr_state_t q;
    pfr_state_t d;

    // ==========================================================
    // helpers
    // small pure functions, shared by write, reload and i/o check paths
    // take writable bits from val, force fixed ones, other bits keep old
    function automatic logic [21:0] fixFlags(input logic [21:0] old, input logic [21:0] val,
                                             input logic [21:0] wmask);
        logic [21:0] m;
        m = wmask & pfr_pkg::FLAG_WR_MASK;
        fixFlags = ((old & ~m) | (val & m)) | pfr_pkg::FLAG_FIXED_ONES;
    endfunction

    // numeric privilege at or below the i/o privilege field
    function automatic logic privOk(input logic [1:0] current_privilege_level, input logic [1:0] io_privilege_level);
        privOk = (current_privilege_level <= io_privilege_level);
    endfunction

    logic [1:0] ioplNow;
    logic ifWriteOk;
    logic vifRedirect;
    logic [21:0] swMask;
    logic [21:0] evtFlags;
    logic takeIrq;
    logic takeAny;
    logic [3:0] evtSet;

    // privilege field as stored now, before this cycle's writes
    assign ioplNow = q.flg[pfr_pkg::IO_PRIVILEGE_LEVEL_LSB +: 2];

    // write mask for the register port:
    //   privileged enough: interrupt enable written directly
    //   otherwise, with v86 extensions or pvi and field below 3,
    //   the enable data is steered into the virtual interrupt bit
    //   otherwise the enable write is dropped silently
    // the v86 bit is never writable here, only by reload
    // the privilege field needs level zero
    // interrupt enable write gating on four inputs
    always_comb
    begin
        ifWriteOk = privOk(currentPrivilegeLevel, ioplNow);
        vifRedirect = !ifWriteOk && (v86ModeExtensionsEnable || protectedVirtualInterruptEnable)
                      && (ioplNow != pfr_pkg::IO_PRIVILEGE_LEVEL_MAX);
        swMask = pfr_pkg::FLAG_WR_MASK;
        swMask[pfr_pkg::V86_BIT] = 1'b0;
        swMask[pfr_pkg::INT_EN_BIT] = ifWriteOk;
        if (currentPrivilegeLevel != 2'h0)
        begin
            swMask[pfr_pkg::IO_PRIVILEGE_LEVEL_LSB +: 2] = 2'h0;
        end
        if (vifRedirect)
        begin
            swMask[pfr_pkg::VIRT_INT_BIT] = 1'b0;
        end
    end

    // ==========================================================
    // next state
    always_comb
    begin
        // defaults: hold state, pulses low, read word zero
        // so every path assigns every field
        d = q;
        evtFlags = q.flg;
        d.dbgExc = 1'b0;
        d.gpFlt = 1'b0;
        d.ioOk = 1'b0;
        d.irqAck = 1'b0;
        d.nmiAck = 1'b0;
        d.rdData = 32'h0000_0000;
        evtSet = 4'h0;

        // arithmetic status bits from the core
        // direction is a control bit and stays with software
        // statusVal order: overflow, sign, zero, aux, parity, carry
        if (statusWe)
        begin
            d.flg[pfr_pkg::OVERFLOW_BIT] = statusVal[5];
            d.flg[pfr_pkg::SIGN_BIT] = statusVal[4];
            d.flg[pfr_pkg::ZERO_BIT] = statusVal[3];
            d.flg[pfr_pkg::AUX_CARRY_BIT] = statusVal[2];
            d.flg[pfr_pkg::PARITY_BIT] = statusVal[1];
            d.flg[pfr_pkg::CARRY_BIT] = statusVal[0];
        end

        // software write of the low word, reserved data dropped
        if (regWr && regAddr == pfr_pkg::FLAGS_LO_OFS)
        begin
            d.flg = fixFlags(d.flg, regWrData[21:0], swMask);
            if (vifRedirect)
            begin
                d.flg[pfr_pkg::VIRT_INT_BIT] = regWrData[pfr_pkg::INT_EN_BIT];
            end
        end
        else if (regWr && regAddr == pfr_pkg::EVT_MASK_OFS)
        begin
            d.evtMask = regWrData[3:0];
        end

        // interrupt return or task switch reloads all bits, v86 included
        // reserved data is dropped and bit 1 forced as on the port
        // it wins over a register write in the same cycle
        if (flagsLoad)
        begin
            d.flg = fixFlags(d.flg, flagsLoadData[21:0], pfr_pkg::FLAG_WR_MASK);
        end

        // instruction completion: single step and resume handling
        // single step: a retire with the trap armed raises the debug
        // exception; arming takes the retire after the one that set
        // the bit, so the setting instruction is never trapped itself
        // resume: cleared per retire, skipped on a retire that comes with a reload or gate
        takeIrq = maskableIrq && q.flg[pfr_pkg::INT_EN_BIT];
        takeAny = takeIrq || nmiReq || softIntReq || excTaken;
        if (instrRetire)
        begin
            if (q.stepArmed)
            begin
                d.dbgExc = 1'b1;
                evtSet[pfr_pkg::EVT_DEBUG] = 1'b1;
            end
            // armed from the value after this instruction
            d.stepArmed = d.flg[pfr_pkg::STEP_BIT] && !q.stepArmed;
            if (q.stepArmed && d.flg[pfr_pkg::STEP_BIT])
            begin
                d.stepArmed = 1'b1;
            end
            if (flagsLoad || taskGateXfer)
            begin
                d.rfDefer = flagsLoad ? flagsLoadData[pfr_pkg::RESUME_BIT] : 1'b1;
            end
            else if (q.rfDefer)
            begin
                // deferred clear lands on the retire after the load
                d.rfDefer = 1'b0;
                d.flg[pfr_pkg::RESUME_BIT] = 1'b0;
            end
            else
            begin
                d.flg[pfr_pkg::RESUME_BIT] = 1'b0;
            end
        end
        else if (!d.flg[pfr_pkg::STEP_BIT])
        begin
            d.stepArmed = 1'b0;
        end

        // any exception or interrupt drops single step
        if (takeAny || d.dbgExc)
        begin
            d.flg[pfr_pkg::STEP_BIT] = 1'b0;
            d.stepArmed = 1'b0;
        end
        d.irqAck = takeIrq;
        d.nmiAck = nmiReq;
        evtSet[pfr_pkg::EVT_INT_ACK] = takeIrq;
        evtSet[pfr_pkg::EVT_NMI_ACK] = nmiReq;

        // i/o address-space permission check
        // exactly one of grant or fault pulses per attempt
        // uses the field before any same-cycle write
        if (ioAttempt)
        begin
            if (privOk(currentPrivilegeLevel, ioplNow))
            begin
                d.ioOk = 1'b1;
            end
            else
            begin
                d.gpFlt = 1'b1;
                evtSet[pfr_pkg::EVT_GP] = 1'b1;
            end
        end

        // sticky events: write one to clear, set wins
        // an event and its clear in one cycle leave the bit set
        // interrupt line follows the next status and mask
        if (regWr && regAddr == pfr_pkg::EVT_STATUS_OFS)
        begin
            d.evtStat = q.evtStat & ~regWrData[3:0];
        end
        d.evtStat = d.evtStat | evtSet;
        d.irq = |(d.evtStat & d.evtMask);

        // read data, one cycle after the strobe
        // reads see the state before this cycle's writes
        // high word and unmapped addresses read as zero
        if (regRd)
        begin
            if (regAddr == pfr_pkg::FLAGS_LO_OFS)
            begin
                d.rdData = {10'h000, q.flg | pfr_pkg::FLAG_FIXED_ONES};
            end
            else if (regAddr == pfr_pkg::FLAGS_HI_OFS)
            begin
                d.rdData = 32'h0000_0000;
            end
            else if (regAddr == pfr_pkg::EVT_STATUS_OFS)
            begin
                d.rdData = {28'h000_0000, q.evtStat};
            end
            else if (regAddr == pfr_pkg::EVT_MASK_OFS)
            begin
                d.rdData = {28'h000_0000, q.evtMask};
            end
            else
            begin
                d.rdData = 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // registers
    // whole state in one register; reset gives flags with bit 1 set,
    // no pulses, empty events and a closed mask
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            q.flg <= pfr_pkg::FLAG_RESET;
            q.stepArmed <= 1'b0;
            q.rfDefer <= 1'b0;
            q.evtStat <= pfr_pkg::EVT_RESET;
            q.evtMask <= pfr_pkg::EVT_RESET;
            q.rdData <= 32'h0000_0000;
            q.dbgExc <= 1'b0;
            q.gpFlt <= 1'b0;
            q.ioOk <= 1'b0;
            q.irqAck <= 1'b0;
            q.nmiAck <= 1'b0;
            q.irq <= 1'b0;
        end
        else
        begin
            q <= d;
        end
    end

    // outputs straight from flops; one storage for both views
    // the high half is constant zero, so no storage is spent on it
    // and the two views can never disagree
    assign flagsControlStatus = {42'h000_0000_0000, q.flg};
    assign legacy32bitFlagsView = {10'h000, q.flg};
    assign regRdData = q.rdData;
    assign debugException = q.dbgExc;
    assign generalProtectionFault = q.gpFlt;
    assign ioGrant = q.ioOk;
    assign irqAccept = q.irqAck;
    assign nmiAccept = q.nmiAck;
    assign intOut = q.irq;

endmodule

// [logic/pfr_pkg.sv]
// package for the processor flags register block
// assumes a single 100 MHz clock domain and a 32-bit register port
package pfr_pkg;
    // ==========================================================
    // flag bit positions
    localparam int unsigned CARRY_BIT = 0;
    localparam int unsigned FIXED_ONE_BIT = 1;
    localparam int unsigned PARITY_BIT = 2;
    localparam int unsigned AUX_CARRY_BIT = 4;
    localparam int unsigned ZERO_BIT = 6;
    localparam int unsigned SIGN_BIT = 7;
    localparam int unsigned STEP_BIT = 8;
    localparam int unsigned INT_EN_BIT = 9;
    localparam int unsigned DIRECTION_BIT = 10;
    localparam int unsigned OVERFLOW_BIT = 11;
    localparam int unsigned IO_PRIVILEGE_LEVEL_LSB = 12;
    localparam int unsigned NESTED_TASK_BIT = 14;
    localparam int unsigned RESUME_BIT = 16;
    localparam int unsigned V86_BIT = 17;
    localparam int unsigned ALIGN_CHECK_BIT = 18;
    localparam int unsigned VIRT_INT_BIT = 19;
    localparam int unsigned VIRT_PEND_BIT = 20;
    localparam int unsigned PROBE_BIT = 21;
    localparam int unsigned FLAG_W = 22;
    // ==========================================================
    // masks and reset values
    localparam logic [21:0] FLAG_WR_MASK = 22'h3f_7fd5;
    localparam logic [21:0] FLAG_FIXED_ONES = 22'h00_0002;
    localparam logic [21:0] FLAG_RESET = 22'h00_0002;
    localparam logic [3:0] EVT_RESET = 4'h0;
    localparam logic [1:0] IO_PRIVILEGE_LEVEL_MAX = 2'h3;
    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] FLAGS_LO_OFS = 8'h00;
    localparam logic [7:0] FLAGS_HI_OFS = 8'h04;
    localparam logic [7:0] EVT_STATUS_OFS = 8'h08;
    localparam logic [7:0] EVT_MASK_OFS = 8'h0c;
    // ==========================================================
    // event bits of status and mask registers
    localparam int unsigned EVT_DEBUG = 0;
    localparam int unsigned EVT_GP = 1;
    localparam int unsigned EVT_INT_ACK = 2;
    localparam int unsigned EVT_NMI_ACK = 3;
endpackage

// [verification/pfr_flags_reg_chk.sv]
// assertions on the ports of the processor flags register
// assumes it is bound into pfr_flags_reg, one clock domain
`timescale 1ns/1ns
module pfr_flags_reg_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic regWr,
    input wire logic [1:0] currentPrivilegeLevel,
    input wire logic instrRetire,
    input wire logic flagsLoad,
    input wire logic taskGateXfer,
    input wire logic maskableIrq,
    input wire logic nmiReq,
    input wire logic softIntReq,
    input wire logic excTaken,
    input wire logic ioAttempt,
    input wire logic [63:0] flagsControlStatus,
    input wire logic [31:0] legacy32bitFlagsView,
    input wire logic debugException,
    input wire logic generalProtectionFault,
    input wire logic ioGrant,
    input wire logic irqAccept,
    input wire logic nmiAccept
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // ==========================================================
    // i/o attempt classes
    sequence io_ok;
        ioAttempt && currentPrivilegeLevel <= flagsControlStatus[13:12];
    endsequence
    sequence io_bad;
        ioAttempt && currentPrivilegeLevel > flagsControlStatus[13:12];
    endsequence
    // ==========================================================
    // layout, privilege and event checks
    a_legacy_view_match: assert property (legacy32bitFlagsView == flagsControlStatus[31:0])
        else $error("legacy view differs");
    a_reserved_read_zero: assert property ({flagsControlStatus[63:22], flagsControlStatus[15],
        flagsControlStatus[5], flagsControlStatus[3]} == 0) else $error("reserved bit set");
    a_fixed_one_bit: assert property (flagsControlStatus[1])
        else $error("bit 1 not one");
    a_io_grant_ok: assert property (io_ok |=> ioGrant && !generalProtectionFault)
        else $error("io not granted");
    a_io_fault_raise: assert property (io_bad |=> generalProtectionFault && !ioGrant)
        else $error("io fault missing");
    a_irq_masked_off: assert property (!flagsControlStatus[9] |=> !irqAccept)
        else $error("masked irq taken");
    a_nmi_always_on: assert property (nmiReq |=> nmiAccept)
        else $error("nmi not taken");
    a_step_off_taken: assert property ((nmiReq || softIntReq || excTaken || (maskableIrq && flagsControlStatus[9]))
        && !flagsLoad && !regWr |=> !flagsControlStatus[8]) else $error("step bit kept");
    a_debug_clears_step: assert property (debugException |-> !flagsControlStatus[8])
        else $error("step bit kept on debug");
    a_resume_cleared: assert property (instrRetire && !flagsLoad && !taskGateXfer && !regWr
        |=> !flagsControlStatus[16]) else $error("resume bit kept");
    a_v86_held_still: assert property (!flagsLoad |=> $stable(flagsControlStatus[17]))
        else $error("v86 bit changed");
endmodule

bind pfr_flags_reg pfr_flags_reg_chk pfr_flags_reg_chk_i (.clk, .nrst, .regWr, .currentPrivilegeLevel,
    .instrRetire, .flagsLoad, .taskGateXfer, .maskableIrq, .nmiReq, .softIntReq, .excTaken, .ioAttempt,
    .flagsControlStatus, .legacy32bitFlagsView, .debugException, .generalProtectionFault, .ioGrant,
    .irqAccept, .nmiAccept);

// [verification/tb.sv]
// self-checking bench for the processor flags register
// assumes pfr_pkg and the design compiled first; bench drives every port
`timescale 1ns/1ns
module tb;
    // ==========================================================
    // stimulus, outputs and model state
    logic clk = 0, nrst = 0, we = 0, re = 0, vme = 0, pvi = 0;
    logic swe, ret, ld, tg, irq, nmi, sw, exc, io;
    logic [8:0] ev = 0;
    logic [7:0] addr = 0;
    logic [31:0] wd = 0, ldd = 0, rdd, lv, r = 85;
    logic [1:0] current_privilege_level = 0;
    logic [5:0] sv = 0;
    logic [63:0] fcs;
    logic dbg, gp, iog, ira, nma, intr;
    int err_count = 0, check_count = 0, m = 2;
    assign {swe, ret, ld, tg, irq, nmi, sw, exc, io} = ev;
    always #5 clk = ~clk;
    pfr_flags_reg pfr_flags_reg_i (.clk(clk), .nrst(nrst), .regAddr(addr), .regWrData(wd), .regWr(we),
        .regRd(re), .regRdData(rdd), .currentPrivilegeLevel(current_privilege_level), .v86ModeExtensionsEnable(vme),
        .protectedVirtualInterruptEnable(pvi), .statusWe(swe), .statusVal(sv), .instrRetire(ret),
        .flagsLoad(ld), .flagsLoadData(ldd), .taskGateXfer(tg), .maskableIrq(irq), .nmiReq(nmi),
        .softIntReq(sw), .excTaken(exc), .ioAttempt(io), .flagsControlStatus(fcs),
        .legacy32bitFlagsView(lv), .debugException(dbg), .generalProtectionFault(gp), .ioGrant(iog),
        .irqAccept(ira), .nmiAccept(nma), .intOut(intr));
    // ==========================================================
    // helpers
    function automatic logic [31:0] nxt(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // model of a register-port write to the low flags word
    function automatic int mw(int o, int d);
        int n;
        n = (o & ~32'h003d_4dd5) | (d & 32'h003d_4dd5);
        if (current_privilege_level == 0)
            n[13:12] = d[13:12];
        if (current_privilege_level <= o[13:12])
            n[9] = d[9];
        else if ((vme || pvi) && o[13:12] != 3)
            n[19] = d[9];
        return n | 2;
    endfunction
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
        check_count++;
        if (s !== e)
        begin
            err_count++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {addr, wd, we} <= {a, d, 1'b1};
        @(posedge clk);
        we <= 0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        @(posedge clk);
        {addr, re} <= {a, 1'b1};
        @(posedge clk);
        re <= 0;
        #1 chk(n, e, rdd);
    endtask
    task automatic pl(input logic [8:0] v, input logic [5:0] s);
        @(posedge clk);
        {ev, sv} <= {v, s};
        @(posedge clk);
        ev <= 0;
        #1;
    endtask
    task automatic ctx(input logic [1:0] c, input logic v, input logic p);
        @(posedge clk);
        {current_privilege_level, vme, pvi} <= {c, v, p};
    endtask
    task automatic wm(input logic [31:0] d);
        wr(8'h00, d);
        m = mw(m, d);
        chk("flags", m, fcs);
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ==========================================================
    // hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        end_sim;
    end
    // ==========================================================
    // main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        nrst <= 1;
        #1 chk("reset", 2, fcs);
        wr(8'h04, 32'hffff_ffff);
        rd(8'h04, 0, "high");
        rd(8'h10, 0, "unmapped");
        for (int k = 0; k < 16; k++)
        begin
            ctx(k[3:2], k[0], k[1]);
            r = nxt(r);
            wm(r);
            chk("legacy", m, lv);
            rd(8'h00, m, "readback");
        end
        r = nxt(r);
        pl(9'h100, r[5:0]);
        m = (m & ~32'h0000_08d5) | {r[5], 3'b0, r[4:3], 1'b0, r[2], 1'b0, r[1], 1'b0, r[0]};
        rd(8'h00, m, "status");
        ctx(0, 0, 0);
        wm(32'h0000_1000);
        for (int k = 0; k < 4; k++)
        begin
            ctx(k, 0, 0);
            pl(9'h001, 0);
            chk("grant", k <= m[13:12], iog);
            chk("fault", k > m[13:12], gp);
        end
        ctx(0, 0, 0);
        pl(9'h010, 0);
        chk("masked", 0, ira);
        wm(32'h0000_1200);
        pl(9'h010, 0);
        chk("accept", 1, ira);
        for (int k = 0; k < 3; k++)
        begin
            wm(32'h0000_1100);
            pl(9'h008 >> k, 0);
            m[8] = 0;
            chk("stepoff", m, fcs);
            if (k == 0)
                chk("nmi", 1, nma);
        end
        wm(32'h0000_1100);
        pl(9'h080, 0);
        chk("nodebug", 0, dbg);
        pl(9'h080, 0);
        chk("debug", 1, dbg);
        m[8] = 0;
        chk("stepclr", m, fcs);
        @(posedge clk);
        ldd <= 32'h0003_1002;
        pl(9'h0c0, 0);
        m = 32'h0003_1002;
        chk("resume", m, fcs);
        pl(9'h080, 0);
        m[16] = 0;
        chk("resclr", m, fcs);
        wm(32'h0000_1002);
        rd(8'h08, 32'h0000_000f, "evstat");
        wr(8'h0c, 32'h0000_0008);
        rd(8'h0c, 32'h0000_0008, "evmask");
        chk("intup", 1, intr);
        wr(8'h08, 32'h0000_0008);
        rd(8'h08, 32'h0000_0007, "evclr");
        chk("intdown", 0, intr);
        end_sim;
    end
endmodule
